// ===== src/ccsl_map.svh
// Register offsets, field positions, reset values and timing counts of the calendar clock
`ifndef CCSL_MAP_SVH
`define CCSL_MAP_SVH

`define CCSL_CUR_WEEKDAY_OFS   8'h00
`define CCSL_CUR_SECONDS_OFS   8'h04
`define CCSL_CUR_HRMIN_OFS     8'h08
`define CCSL_CUR_MONDAY_OFS    8'h0c
`define CCSL_CUR_CENTYEAR_OFS  8'h10
`define CCSL_STOP_SECONDS_OFS  8'h14
`define CCSL_STOP_HRMIN_OFS    8'h18
`define CCSL_STOP_MONDAY_OFS   8'h1c
`define CCSL_STOP_CENTYEAR_OFS 8'h20
`define CCSL_STOP_WDCAUSE_OFS  8'h24
`define CCSL_ADJUST_OFS        8'h28
`define CCSL_CTRL_OFS          8'h2c

`define CCSL_CTRL_WRITE_EN_BIT 0
`define CCSL_CTRL_ADJUST_EN_BIT 1

`define CCSL_F_WEEKDAY 0
`define CCSL_F_SECONDS 1
`define CCSL_F_MINUTES 2
`define CCSL_F_HOURS   3
`define CCSL_F_DAY     4
`define CCSL_F_MONTH   5
`define CCSL_F_YEAR    6
`define CCSL_F_CENTURY 7
`define CCSL_NUM_FIELDS 8

`define CCSL_TIME_RESET 64'h0000_0101_0000_0001
`define CCSL_STOP_RESET 64'h0000_0000_0000_0000

`define CCSL_CAUSE_STOP_MODE   8'h01
`define CCSL_CAUSE_SW_FAULT    8'h02
`define CCSL_CAUSE_POWER_BREAK 8'h04
`define CCSL_CAUSE_HW_FAULT    8'h05
`define CCSL_CAUSE_HALT        8'h06

`define CCSL_CLK_HZ          40000000
`define CCSL_TICK_PERIOD_MS  1000
`define CCSL_TICK_CYCLES     ((`CCSL_CLK_HZ / 1000) * `CCSL_TICK_PERIOD_MS)

`endif

// ===== src/ccsl_pkg.sv
// Types shared by the calendar clock modules
package ccsl_pkg;

  typedef logic [7:0][7:0] ccsl_time_type;

  typedef enum logic [3:0] {
    BUS_IDLE   = 4'b0001,
    BUS_WRITE  = 4'b0010,
    BUS_RDWAIT = 4'b0100,
    BUS_RDOUT  = 4'b1000
  } ccsl_bus_state_type;

  typedef struct packed {
    logic mode_req;
    logic sw_fault;
    logic power_break;
    logic hw_fault;
    logic halt_exec;
  } ccsl_stop_req_type;

  typedef struct packed {
    ccsl_bus_state_type bus;
    logic [7:0]         addr;
    logic               write_en;
    logic               adjust_en;
    logic [15:0]        adjust;
    ccsl_time_type      now;
    ccsl_time_type      stop_time;
    logic [7:0]         cause;
    logic [25:0]        tick_cnt;
    logic               tick_pending;
    logic [31:0]        rdata;
  } ccsl_state_type;

endpackage

// ===== src/ccsl_bcd_step.sv
// One BCD field stepped up or down with wrap between a low and a high bound
`timescale 1ns/100ps
module ccsl_bcd_step (
  input  wire logic [7:0] val,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  input  wire logic       up,
  input  wire logic       down,
  output logic      [7:0] nxt,
  output logic            wrap
);

  // BCD keeps binary ordering, so plain compares work on the bounds
  always_comb begin
    nxt  = val;
    wrap = 1'b0;
    if (up && !down) begin
      if (val >= hi) begin
        nxt  = lo;
        wrap = 1'b1;
      end else if (val[3:0] == 4'h9) begin
        nxt = {val[7:4] + 4'h1, 4'h0};
      end else begin
        nxt = {val[7:4], val[3:0] + 4'h1};
      end
    end else if (down && !up) begin
      if (val <= lo) begin
        nxt = hi;
      end else if (val[3:0] == 4'h0) begin
        nxt = {val[7:4] - 4'h1, 4'h9};
      end else begin
        nxt = {val[7:4], val[3:0] - 4'h1};
      end
    end
  end

endmodule // ccsl_bcd_step

// ===== src/ccsl_rtc.sv
// Calendar clock with stop log behind an AHB-Lite register slave
// Function
// RL1 - Keep live date and time in five words
// RL2 - All fields BCD in the given byte layout
// RL3 - Write enable clear: words read only, live
// RL4 - Write enable set: writes replace clock contents
// RL5 - Adjust enable set: step fields from current value
// RL6 - Adjust bits 0-7 increment the eight fields
// RL7 - Adjust bits 8-15 decrement the eight fields
// RL8 - No automatic daylight-saving hour shift
// RL9 - On stop, capture date and time
// RL10 - Stop record words in their own layout
// RL11 - Program reads stop record, cannot set it
// RL12 - Stop cause BCD in last word low byte
// RL13 - Requested stop records cause 1
// RL14 - Software fault stop records cause 2
// RL15 - Power break or reset button records 4
// RL16 - Hardware fault stop records cause 5
// RL17 - Halt instruction stop records cause 6
// RL18 - One-second tick carries through full calendar
// RL19 - Each adjust bit steps once, then clears
`timescale 1ns/100ps
`include "ccsl_map.svh"
module ccsl_rtc #(
  parameter logic [25:0] TICK_CYCLES = 26'(`CCSL_TICK_CYCLES)
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire ccsl_pkg::ccsl_stop_req_type stop_req
);

  ccsl_pkg::ccsl_state_type s_reg;
  ccsl_pkg::ccsl_state_type s_next;

  logic [7:0] lo   [`CCSL_NUM_FIELDS];
  logic [7:0] hi   [`CCSL_NUM_FIELDS];
  logic [7:0] stepped [`CCSL_NUM_FIELDS];
  logic [`CCSL_NUM_FIELDS-1:0] up;
  logic [`CCSL_NUM_FIELDS-1:0] down;
  logic [`CCSL_NUM_FIELDS-1:0] wrap;
  logic [`CCSL_NUM_FIELDS-1:0] chain;
  logic       accept;
  logic       cur_wr;
  logic       apply_adj;
  logic       do_tick;
  logic       stop_any;
  logic [7:0] stop_code;

  // Days in month from BCD month, year and century; leap years follow the Gregorian rule
  function automatic logic [7:0] ccsl_dim(input logic [7:0] mon,
                                          input logic [7:0] yr,
                                          input logic [7:0] cen);
    logic [1:0] ym;
    logic [1:0] cm;
    logic       leap;
    ym   = {yr[1] ^ yr[4], yr[0]};
    cm   = {cen[1] ^ cen[4], cen[0]};
    leap = (ym == 2'b00) && ((yr != 8'h00) || (cm == 2'b00));
    case (mon)
      8'h02:                      ccsl_dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: ccsl_dim = 8'h30;
      default:                    ccsl_dim = 8'h31;
    endcase
  endfunction

  // Register read view, live values in the current words
  function automatic logic [31:0] ccsl_read(input ccsl_pkg::ccsl_state_type s);
    logic [15:0] w;
    w = 16'h0000;
    case (s.addr)
      `CCSL_CUR_WEEKDAY_OFS:   w = {8'h00, s.now[`CCSL_F_WEEKDAY]};                    // [RL2]
      `CCSL_CUR_SECONDS_OFS:   w = {s.now[`CCSL_F_SECONDS], 8'h00};
      `CCSL_CUR_HRMIN_OFS:     w = {s.now[`CCSL_F_HOURS], s.now[`CCSL_F_MINUTES]};
      `CCSL_CUR_MONDAY_OFS:    w = {s.now[`CCSL_F_MONTH], s.now[`CCSL_F_DAY]};
      `CCSL_CUR_CENTYEAR_OFS:  w = {s.now[`CCSL_F_CENTURY], s.now[`CCSL_F_YEAR]};
      `CCSL_STOP_SECONDS_OFS:  w = {s.stop_time[`CCSL_F_SECONDS], 8'h00};              // [RL10]
      `CCSL_STOP_HRMIN_OFS:    w = {s.stop_time[`CCSL_F_HOURS], s.stop_time[`CCSL_F_MINUTES]};
      `CCSL_STOP_MONDAY_OFS:   w = {s.stop_time[`CCSL_F_MONTH], s.stop_time[`CCSL_F_DAY]};
      `CCSL_STOP_CENTYEAR_OFS: w = {s.stop_time[`CCSL_F_CENTURY], s.stop_time[`CCSL_F_YEAR]};
      `CCSL_STOP_WDCAUSE_OFS:  w = {s.stop_time[`CCSL_F_WEEKDAY], s.cause};             // [RL12]
      `CCSL_ADJUST_OFS:        w = s.adjust;
      `CCSL_CTRL_OFS:          w = {14'h0000, s.adjust_en, s.write_en};
      default:                 w = 16'h0000;
    endcase
    ccsl_read = {16'h0000, w};
  endfunction

  assign accept    = hsel && hready && htrans[1];
  assign hreadyout = (s_reg.bus != ccsl_pkg::BUS_RDWAIT);
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata;

  // Write to a current word lands only while write enable is set
  assign cur_wr = (s_reg.bus == ccsl_pkg::BUS_WRITE) && s_reg.write_en &&
                  (s_reg.addr <= `CCSL_CUR_CENTYEAR_OFS) && (s_reg.addr[1:0] == 2'b00); // [RL3] [RL4]
  assign apply_adj = s_reg.adjust_en && (s_reg.adjust != 16'h0000) && !cur_wr;         // [RL5]
  // A pending tick waits out writes and adjusts rather than racing them
  assign do_tick   = s_reg.tick_pending && !apply_adj && !cur_wr;

  // Carry chain of normal timekeeping; hours only ever move by carry here [RL8]
  assign chain[`CCSL_F_SECONDS] = do_tick;                                              // [RL18]
  assign chain[`CCSL_F_MINUTES] = chain[`CCSL_F_SECONDS] && wrap[`CCSL_F_SECONDS];
  assign chain[`CCSL_F_HOURS]   = chain[`CCSL_F_MINUTES] && wrap[`CCSL_F_MINUTES];
  assign chain[`CCSL_F_DAY]     = chain[`CCSL_F_HOURS] && wrap[`CCSL_F_HOURS];
  assign chain[`CCSL_F_WEEKDAY] = chain[`CCSL_F_DAY];
  assign chain[`CCSL_F_MONTH]   = chain[`CCSL_F_DAY] && wrap[`CCSL_F_DAY];
  assign chain[`CCSL_F_YEAR]    = chain[`CCSL_F_MONTH] && wrap[`CCSL_F_MONTH];
  assign chain[`CCSL_F_CENTURY] = chain[`CCSL_F_YEAR] && wrap[`CCSL_F_YEAR];

  always_comb begin
    lo[`CCSL_F_WEEKDAY] = 8'h01;
    hi[`CCSL_F_WEEKDAY] = 8'h07;
    lo[`CCSL_F_SECONDS] = 8'h00;
    hi[`CCSL_F_SECONDS] = 8'h59;
    lo[`CCSL_F_MINUTES] = 8'h00;
    hi[`CCSL_F_MINUTES] = 8'h59;
    lo[`CCSL_F_HOURS]   = 8'h00;
    hi[`CCSL_F_HOURS]   = 8'h23;
    lo[`CCSL_F_DAY]     = 8'h01;
    hi[`CCSL_F_DAY]     = ccsl_dim(s_reg.now[`CCSL_F_MONTH], s_reg.now[`CCSL_F_YEAR],
                                   s_reg.now[`CCSL_F_CENTURY]);
    lo[`CCSL_F_MONTH]   = 8'h01;
    hi[`CCSL_F_MONTH]   = 8'h12;
    lo[`CCSL_F_YEAR]    = 8'h00;
    hi[`CCSL_F_YEAR]    = 8'h99;
    lo[`CCSL_F_CENTURY] = 8'h00;
    hi[`CCSL_F_CENTURY] = 8'h99;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CCSL_NUM_FIELDS; gi++) begin : g_field
      // Adjust steps each field alone, no carry into its neighbour
      assign up[gi]   = apply_adj ? s_reg.adjust[gi] : chain[gi];                      // [RL6]
      assign down[gi] = apply_adj && s_reg.adjust[gi+8];                                // [RL7]
      ccsl_bcd_step u_step (
        .val  (s_reg.now[gi]),
        .lo   (lo[gi]),
        .hi   (hi[gi]),
        .up   (up[gi]),
        .down (down[gi]),
        .nxt  (stepped[gi]),
        .wrap (wrap[gi])
      );
    end
  endgenerate

  // Power loss outranks faults, faults outrank orderly stops
  assign stop_any = |stop_req;
  always_comb begin
    if (stop_req.power_break) begin
      stop_code = `CCSL_CAUSE_POWER_BREAK;                                              // [RL15]
    end else if (stop_req.hw_fault) begin
      stop_code = `CCSL_CAUSE_HW_FAULT;                                                 // [RL16]
    end else if (stop_req.sw_fault) begin
      stop_code = `CCSL_CAUSE_SW_FAULT;                                                 // [RL14]
    end else if (stop_req.halt_exec) begin
      stop_code = `CCSL_CAUSE_HALT;                                                     // [RL17]
    end else begin
      stop_code = `CCSL_CAUSE_STOP_MODE;                                                // [RL13]
    end
  end

  always_comb begin
    s_next = s_reg;

    // Bus phase tracking
    case (s_reg.bus)
      ccsl_pkg::BUS_RDWAIT: begin
        s_next.rdata = ccsl_read(s_reg);
        s_next.bus   = ccsl_pkg::BUS_RDOUT;
      end
      ccsl_pkg::BUS_IDLE, ccsl_pkg::BUS_WRITE, ccsl_pkg::BUS_RDOUT: begin
        if (accept) begin
          s_next.addr = haddr[7:0];
          s_next.bus  = hwrite ? ccsl_pkg::BUS_WRITE : ccsl_pkg::BUS_RDWAIT;
        end else begin
          s_next.bus = ccsl_pkg::BUS_IDLE;
        end
      end
      default: begin
        s_next.bus = ccsl_pkg::BUS_IDLE;
      end
    endcase

    // One-second time base; a new tick wins over the clear of the pending one
    if (do_tick) begin
      s_next.tick_pending = 1'b0;
    end
    if (s_reg.tick_cnt >= TICK_CYCLES - 26'd1) begin
      s_next.tick_cnt     = 26'd0;
      s_next.tick_pending = 1'b1;                                                       // [RL18]
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 26'd1;
    end

    // Stepping by tick or adjust, every field at once [RL1]
    for (int i = 0; i < `CCSL_NUM_FIELDS; i++) begin
      s_next.now[i] = stepped[i];
    end
    if (apply_adj) begin
      s_next.adjust = 16'h0000;                                                         // [RL19]
    end

    // Register writes; stop record words have no write path [RL11]
    if (s_reg.bus == ccsl_pkg::BUS_WRITE) begin
      case (s_reg.addr)
        `CCSL_ADJUST_OFS: s_next.adjust = hwdata[15:0];
        `CCSL_CTRL_OFS: begin
          s_next.write_en  = hwdata[`CCSL_CTRL_WRITE_EN_BIT];
          s_next.adjust_en = hwdata[`CCSL_CTRL_ADJUST_EN_BIT];
        end
        default: begin
        end
      endcase
    end
    if (cur_wr) begin
      case (s_reg.addr)
        `CCSL_CUR_WEEKDAY_OFS: s_next.now[`CCSL_F_WEEKDAY] = hwdata[7:0];               // [RL4]
        `CCSL_CUR_SECONDS_OFS: s_next.now[`CCSL_F_SECONDS] = hwdata[15:8];
        `CCSL_CUR_HRMIN_OFS: begin
          s_next.now[`CCSL_F_HOURS]   = hwdata[15:8];
          s_next.now[`CCSL_F_MINUTES] = hwdata[7:0];
        end
        `CCSL_CUR_MONDAY_OFS: begin
          s_next.now[`CCSL_F_MONTH] = hwdata[15:8];
          s_next.now[`CCSL_F_DAY]   = hwdata[7:0];
        end
        default: begin
          s_next.now[`CCSL_F_CENTURY] = hwdata[15:8];
          s_next.now[`CCSL_F_YEAR]    = hwdata[7:0];
        end
      endcase
    end

    // Stop log takes the time as it stood before this edge
    if (stop_any) begin
      s_next.stop_time = s_reg.now;                                                     // [RL9]
      s_next.cause     = stop_code;                                                     // [RL12]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg.bus          <= ccsl_pkg::BUS_IDLE;
      s_reg.addr         <= 8'h00;
      s_reg.write_en     <= 1'b0;
      s_reg.adjust_en    <= 1'b0;
      s_reg.adjust       <= 16'h0000;
      s_reg.now          <= `CCSL_TIME_RESET;
      s_reg.stop_time    <= `CCSL_STOP_RESET;
      s_reg.cause        <= 8'h00;
      s_reg.tick_cnt     <= 26'd0;
      s_reg.tick_pending <= 1'b0;
      s_reg.rdata        <= 32'h0000_0000;
    end else begin
      s_reg <= s_next;
    end
  end

  AST_BCD_SECONDS: assert property (@(posedge hclk) disable iff (!hresetn) // [RL2]
    (s_reg.now[`CCSL_F_SECONDS] <= 8'h59) && (s_reg.now[`CCSL_F_SECONDS][3:0] <= 4'h9))
    else $error("seconds field left BCD range");

  AST_WRITE_BLOCKED: assert property (@(posedge hclk) disable iff (!hresetn) // [RL3]
    (s_reg.bus == ccsl_pkg::BUS_WRITE) && !s_reg.write_en && !s_reg.tick_pending &&
    !apply_adj && (s_reg.addr == `CCSL_CUR_HRMIN_OFS)
    |=> $stable(s_reg.now[`CCSL_F_HOURS]))
    else $error("hours changed by a write while write enable was clear");

  AST_WRITE_LOAD: assert property (@(posedge hclk) disable iff (!hresetn) // [RL4]
    cur_wr && (s_reg.addr == `CCSL_CUR_HRMIN_OFS) && !stop_any
    |=> (s_reg.now[`CCSL_F_HOURS] == $past(hwdata[15:8])) &&
        (s_reg.now[`CCSL_F_MINUTES] == $past(hwdata[7:0])))
    else $error("hours and minutes not loaded from write data");

  AST_ADJ_INC: assert property (@(posedge hclk) disable iff (!hresetn) // [RL6]
    apply_adj && s_reg.adjust[`CCSL_F_MINUTES] && !s_reg.adjust[`CCSL_F_MINUTES+8] &&
    (s_reg.now[`CCSL_F_MINUTES] < 8'h59)
    |=> s_reg.now[`CCSL_F_MINUTES] > $past(s_reg.now[`CCSL_F_MINUTES]))
    else $error("minutes not incremented by adjust");

  AST_ADJ_DEC: assert property (@(posedge hclk) disable iff (!hresetn) // [RL7]
    apply_adj && s_reg.adjust[`CCSL_F_HOURS+8] && !s_reg.adjust[`CCSL_F_HOURS] &&
    (s_reg.now[`CCSL_F_HOURS] != 8'h00)
    |=> s_reg.now[`CCSL_F_HOURS] < $past(s_reg.now[`CCSL_F_HOURS]))
    else $error("hours not decremented by adjust");

  AST_ADJ_ONCE: assert property (@(posedge hclk) disable iff (!hresetn) // [RL19]
    apply_adj && !((s_reg.bus == ccsl_pkg::BUS_WRITE) && (s_reg.addr == `CCSL_ADJUST_OFS))
    |=> (s_reg.adjust == 16'h0000) ##1 ($stable(s_reg.now[`CCSL_F_SECONDS]) ||
        $past(do_tick) || $past(cur_wr) || $past(apply_adj)))
    else $error("adjust word not cleared after one step");

  AST_TICK_SECONDS: assert property (@(posedge hclk) disable iff (!hresetn) // [RL18]
    do_tick |=> s_reg.now[`CCSL_F_SECONDS] != $past(s_reg.now[`CCSL_F_SECONDS]))
    else $error("tick did not move the seconds field");

  AST_STOP_CAPTURE: assert property (@(posedge hclk) disable iff (!hresetn) // [RL9]
    stop_any |=> (s_reg.stop_time == $past(s_reg.now)))
    else $error("stop record does not hold the time of the stop");

  AST_CAUSE_POWER: assert property (@(posedge hclk) disable iff (!hresetn) // [RL15]
    stop_req.power_break |=> (s_reg.cause == 8'h04))
    else $error("power break not recorded as cause 4");

  AST_CAUSE_HALT: assert property (@(posedge hclk) disable iff (!hresetn) // [RL17]
    stop_req.halt_exec && !stop_req.power_break && !stop_req.hw_fault && !stop_req.sw_fault
    |=> (s_reg.cause == 8'h06))
    else $error("halt stop not recorded as cause 6");

  AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn) // [RL1]
    accept && !hwrite |=> !hreadyout ##1 hreadyout && (hrdata[31:16] == 16'h0000))
    else $error("read answer not given after exactly one wait state");

  AST_BCD_WEEKDAY: assert property (@(posedge hclk) disable iff (!hresetn) // [RL2]
    (s_reg.now[`CCSL_F_WEEKDAY] >= 8'h01) && (s_reg.now[`CCSL_F_WEEKDAY] <= 8'h07))
    else $error("weekday field left its range");

  AST_BCD_HOURS: assert property (@(posedge hclk) disable iff (!hresetn) // [RL2]
    (s_reg.now[`CCSL_F_HOURS] <= 8'h23) && (s_reg.now[`CCSL_F_HOURS][3:0] <= 4'h9))
    else $error("hours field left BCD range");

  AST_HOURS_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // [RL8]
    !chain[`CCSL_F_HOURS] && !apply_adj && !cur_wr |=> $stable(s_reg.now[`CCSL_F_HOURS]))
    else $error("hours moved without carry, write or adjust");

  AST_CAUSE_MODE: assert property (@(posedge hclk) disable iff (!hresetn) // [RL13]
    stop_req.mode_req && !stop_req.power_break && !stop_req.hw_fault &&
    !stop_req.sw_fault && !stop_req.halt_exec |=> (s_reg.cause == 8'h01))
    else $error("requested stop not recorded as cause 1");

  AST_CAUSE_SW: assert property (@(posedge hclk) disable iff (!hresetn) // [RL14]
    stop_req.sw_fault && !stop_req.power_break && !stop_req.hw_fault
    |=> (s_reg.cause == 8'h02))
    else $error("software fault stop not recorded as cause 2");

  AST_CAUSE_HW: assert property (@(posedge hclk) disable iff (!hresetn) // [RL16]
    stop_req.hw_fault && !stop_req.power_break |=> (s_reg.cause == 8'h05))
    else $error("hardware fault stop not recorded as cause 5");

endmodule // ccsl_rtc

// ===== tb/ccsl_rtc_test.sv
// Self-checking bench for the calendar clock with stop log
`timescale 1ns/100ps
module ccsl_rtc_test;
  // Short tick so rollovers happen quickly; every scenario after the reset check runs just after a tick
  localparam int TICK = 1500;
  logic                        hclk;
  logic                        hresetn;
  logic                        hsel;
  logic [31:0]                 haddr;
  logic [1:0]                  htrans;
  logic                        hwrite;
  logic [2:0]                  hsize;
  logic [31:0]                 hwdata;
  logic                        hready;
  logic [31:0]                 hrdata;
  logic                        hreadyout;
  logic                        hresp;
  ccsl_pkg::ccsl_stop_req_type stop_req;
  int                          err_total;
  int                          checks_done;
  logic [31:0]                 rd;
  // Adjustable fields in adjust-word bit order: word, upper byte flag, top and bottom of range
  logic [7:0]  f_ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h10, 8'h10};
  logic        f_hi  [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0]  f_top [8] = '{8'h07, 8'h59, 8'h59, 8'h23, 8'h31, 8'h12, 8'h99, 8'h99};
  logic [7:0]  f_bot [8] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
  // Calendar cases at 23:59:59: century/year and month/day before, month/day after
  logic [15:0] c_cy  [6] = '{16'h1999, 16'h2024, 16'h2023, 16'h2100, 16'h2000, 16'h2023};
  logic [15:0] c_md  [6] = '{16'h1231, 16'h0228, 16'h0228, 16'h0228, 16'h0228, 16'h0430};
  logic [15:0] c_md2 [6] = '{16'h0101, 16'h0229, 16'h0301, 16'h0301, 16'h0229, 16'h0501};
  // Stop causes: request bits and the code each must leave
  logic [4:0]  s_req [6] = '{5'b10000,
                             5'b01000,
                             5'b00100,
                             5'b00010,
                             5'b00001,
                             5'b00101};
  logic [7:0]  s_code [6] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h04};

  assign hready = hreadyout;

  ccsl_rtc #(
    .TICK_CYCLES (26'(TICK))
  ) u_ccsl_rtc (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .stop_req  (stop_req)
  );

  always #12.5 hclk = ~hclk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single transfer; waits on hready without assuming any count of wait states
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0, wd};
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    rd = hrdata;
    chk({15'h0, hresp}, 16'h0000, "bus response");
  endtask

  task automatic rdw(input logic [7:0] a, input logic [15:0] e, input string what);
    bus(1'b0, a, 16'h0);
    chk(rd[15:0], e, what);
    chk(rd[31:16], 16'h0000, "upper half");
  endtask

  task automatic set_time(input logic [15:0] w0, w1, w2, w3, w4);
    bus(1'b1, 8'h2c, 16'h0001);
    bus(1'b1, 8'h00, w0);
    bus(1'b1, 8'h04, w1);
    bus(1'b1, 8'h08, w2);
    bus(1'b1, 8'h0c, w3);
    bus(1'b1, 8'h10, w4);
    bus(1'b1, 8'h2c, 16'h0000);
  endtask

  // Returns just after the seconds word changes, leaving a quiet span of one tick
  task automatic sync_tick();
    logic [15:0] s0;
    bus(1'b0, 8'h04, 16'h0);
    s0 = rd[15:0];
    do begin
      bus(1'b0, 8'h04, 16'h0);
    end while (rd[15:0] === s0);
  endtask

  task automatic t_reset();
    rdw(8'h00, 16'h0001, "weekday at reset");
    rdw(8'h04, 16'h0000, "seconds at reset");
    rdw(8'h08, 16'h0000, "hours minutes at reset");
    rdw(8'h0c, 16'h0101, "month day at reset");
    rdw(8'h10, 16'h0000, "century year at reset");
    rdw(8'h24, 16'h0000, "stop cause at reset");
    bus(1'b1, 8'h30, 16'hffff);
    rdw(8'h30, 16'h0000, "unmapped word");
  endtask

  task automatic t_write();
    sync_tick();
    bus(1'b1, 8'h08, 16'h1234);
    rdw(8'h08, 16'h0000, "write while locked");
    set_time(16'h0003, 16'h4500, 16'h2159, 16'h0228, 16'h2024);
    rdw(8'h00, 16'h0003, "weekday loaded");
    rdw(8'h04, 16'h4500, "seconds loaded");
    rdw(8'h08, 16'h2159, "hours minutes loaded");
    rdw(8'h0c, 16'h0228, "month day loaded");
    rdw(8'h10, 16'h2024, "century year loaded");
    bus(1'b1, 8'h14, 16'hffff);
    bus(1'b1, 8'h24, 16'hffff);
    rdw(8'h14, 16'h0000, "stop seconds written");
    rdw(8'h24, 16'h0000, "stop cause written");
  endtask

  // Seconds tick carried through every field, including month lengths and leap years
  task automatic t_calendar();
    sync_tick();
    for (int i = 0; i < 6; i++) begin
      set_time(16'h0007, 16'h5900, 16'h2359, c_md[i], c_cy[i]);
      sync_tick();
      rdw(8'h00, 16'h0001, "weekday after midnight");
      rdw(8'h04, 16'h0000, "seconds after carry");
      rdw(8'h08, 16'h0000, "hours after carry");
      rdw(8'h0c, c_md2[i], "month day after carry");
      rdw(8'h10, (i == 0) ? 16'h2000 : c_cy[i], "century year after carry");
    end
  endtask

  task automatic t_adjust();
    sync_tick();
    set_time(16'h0007, 16'h5900, 16'h2359, 16'h1231, 16'h9999);
    bus(1'b1, 8'h2c, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h28, 16'h0001 << i);
      bus(1'b0, f_ofs[i], 16'h0);
      chk(f_hi[i] ? {8'h0, rd[15:8]} : {8'h0, rd[7:0]}, {8'h0, f_bot[i]}, "step up");
      rdw(8'h28, 16'h0000, "adjust word after step");
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'h28, 16'h0100 << i);
      bus(1'b0, f_ofs[i], 16'h0);
      chk(f_hi[i] ? {8'h0, rd[15:8]} : {8'h0, rd[7:0]}, {8'h0, f_top[i]}, "step down");
      rdw(8'h28, 16'h0000, "adjust word after step");
    end
    // Steps away from the range ends, so no wrap hides a wrong direction
    bus(1'b1, 8'h28, 16'h0c00);
    bus(1'b1, 8'h28, 16'h0004);
    rdw(8'h08, 16'h2259, "hours minutes after inner steps");
    // With stepping disabled the request must wait and leave the clock alone
    bus(1'b1, 8'h2c, 16'h0000);
    bus(1'b1, 8'h28, 16'h0001);
    rdw(8'h00, 16'h0007, "step while disabled");
  endtask

  task automatic t_stop();
    sync_tick();
    set_time(16'h0005, 16'h3700, 16'h1542, 16'h0611, 16'h2031);
    for (int i = 0; i < 6; i++) begin
      @(posedge hclk);
      stop_req <= ccsl_pkg::ccsl_stop_req_type'(s_req[i]);
      @(posedge hclk);
      stop_req <= '0;
      rdw(8'h14, 16'h3700, "stop seconds");
      rdw(8'h18, 16'h1542, "stop hours minutes");
      rdw(8'h1c, 16'h0611, "stop month day");
      rdw(8'h20, 16'h2031, "stop century year");
      rdw(8'h24, {8'h05, s_code[i]}, "stop weekday and cause");
    end
  endtask

  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    hclk        = 1'b0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    stop_req    = '0;
    err_total   = 0;
    checks_done = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_write();
    t_calendar();
    t_adjust();
    t_stop();
    wrap_up();
  end

  // About ten ticks are needed; forty leave ample margin
  initial begin
    repeat (40 * TICK) @(posedge hclk);
    err_total++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // ccsl_rtc_test
